// ---- lbx_buf.sv ----
// small valid/ready buffer, registered handshake outputs
// assumes one clock, async active-low reset
`timescale 1ns/1ps
module lbx_buf #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [CW-1:0] count;
    logic [CW-1:0] next_count;
    logic push;
    logic pop;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr];

    always_comb
    begin
        next_count = count;
        if (push && !pop)
        begin
            next_count = count + CW'(1);
        end
        else if (pop && !push)
        begin
            next_count = count - CW'(1);
        end
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            count <= '0;
            in_ready <= 1'b1;
            out_valid <= 1'b0;
        end
        else
        begin
            count <= next_count;
            in_ready <= (next_count != CW'(DEPTH));
            out_valid <= (next_count != '0);
        end
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
            end
            if (pop)
            begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (push)
        begin
            mem[wr_ptr] <= in_data;
        end
    end

endmodule

// ---- lbx_consts.svh ----
// register offsets, reset values and bit counts of the legacy link byte path
// assumes inclusion by bare name from the design files
`ifndef LBX_CONSTS_SVH
`define LBX_CONSTS_SVH

`define LBX_OFS_RX_BYTE 8'h28
`define LBX_OFS_MATCH_ONE 8'h29
`define LBX_OFS_MATCH_TWO 8'h2a
`define LBX_OFS_TX_BYTE 8'h7e
`define LBX_RST_BYTE 8'h00
`define LBX_UNMAPPED_READ 8'h00
`define LBX_LAST_BIT 3'h7
`define LBX_ONES_RUN 3'h5
`define LBX_ONES_MAX 3'h6

`endif

// ---- lbx_far_end.sv ----
// far-end model: framer receive bit stream and capture of transmitted link bits
// assumes the bench pulses rx_go at a falling edge of mclk and waits for rx_busy low
`timescale 1ns/1ps
module lbx_far_end (
    input wire logic mclk,
    input wire logic rx_go,
    input wire logic [7:0] rx_byte,
    output lbx_pkg::lbx_bit_s rx_in,
    output logic rx_busy,
    input wire lbx_pkg::lbx_bit_s tx_out,
    output logic [15:0] tx_cap
);
    initial
    begin
        rx_in = '0;
        rx_busy = 1'b0;
        tx_cap = 16'h0000;
    end
    // byte sent lsb first, one slot per bit, line inverted between slots
    always @(posedge rx_go)
    begin
        rx_busy = 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            @(negedge mclk);
            rx_in.slot <= 1'b1;
            rx_in.value <= rx_byte[i];
            @(negedge mclk);
            rx_in.slot <= 1'b0;
            rx_in.value <= ~rx_byte[i];
            @(negedge mclk);
        end
        rx_busy = 1'b0;
    end
    // transmitted bits in arrival order, newest at the top
    always @(posedge mclk)
        if (tx_out.slot)
            tx_cap <= {tx_out.value, tx_cap[15:1]};
endmodule

// ---- lbx_link_byte.sv ----
// legacy link byte insert and extract path of a t1 framer
// assumes framer slot strobes and host port are synchronous to mclk
// Functional notes
// - link byte matching either match byte flags, interrupts
// - match registers hold 8-bit pattern, bit7 msb
// - esf uses link slots, d4 uses fs slots
// - written byte sent lsb first, bit per slot
// - empty flag set after eighth bit sent
// - empty flag with mask drives irq low
// - no new byte means resend held byte
// - stuffing inserts zero after five ones
// - multiframe load mode loads only on boundaries
// - fs message fields via rx/tx bytes
// - rx bits lsb first, full flag each byte
// - destuff drops zero after exactly five ones
`timescale 1ns/1ps
`include "lbx_consts.svh"
module lbx_link_byte #(
    parameter int BUF_DEPTH = 2
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [7:0] cpu_addr,
    input wire logic cpu_wr,
    input wire logic cpu_rd,
    input wire logic [7:0] cpu_wdata,
    output logic [7:0] cpu_rdata,
    output logic tx_write_ready,
    input wire lbx_pkg::lbx_ctrl_s ctrl,
    input wire lbx_pkg::lbx_flags_s irq_mask,
    input wire lbx_pkg::lbx_flags_s flag_clear,
    output lbx_pkg::lbx_flags_s flags,
    output logic irq_n,
    input wire lbx_pkg::lbx_bit_s rx_in,
    input wire logic tx_link_slot,
    input wire logic tx_fs_slot,
    input wire logic tx_mf_boundary,
    input wire logic fs_alt_bit,
    output lbx_pkg::lbx_bit_s tx_out
);
    logic [7:0] match_one;
    logic [7:0] match_two;
    logic [7:0] tx_written;
    logic [7:0] rx_link_byte;
    logic [7:0] rx_shift;
    logic [2:0] rx_count;
    logic [2:0] rx_ones;
    logic [7:0] cur_byte;
    logic [2:0] tx_count;
    logic [2:0] tx_ones;
    logic buf_ready;
    logic buf_valid;
    logic [7:0] buf_data;
    logic wr_tx;
    logic tx_slot;
    logic tx_alt;
    logic tx_start;
    logic tx_stuff;
    logic load_ok;
    logic tx_pop;
    logic tx_adv;
    logic [7:0] byte_now;
    logic tx_bit;
    logic rx_drop;
    logic rx_take;
    logic rx_done;
    logic [7:0] rx_new;
    lbx_pkg::lbx_flags_s set_ev;
    lbx_pkg::lbx_flags_s next_flags;

    // host port writes
    assign wr_tx = cpu_wr && (cpu_addr == `LBX_OFS_TX_BYTE);

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            match_one <= `LBX_RST_BYTE;
            match_two <= `LBX_RST_BYTE;
            tx_written <= `LBX_RST_BYTE;
        end
        else if (cpu_wr)
        begin
            if (cpu_addr == `LBX_OFS_MATCH_ONE)
            begin
                match_one <= cpu_wdata;
            end
            if (cpu_addr == `LBX_OFS_MATCH_TWO)
            begin
                match_two <= cpu_wdata;
            end
            if (wr_tx && buf_ready)
            begin
                tx_written <= cpu_wdata;
            end
        end
    end

    // registered read data; fs message fields share these bytes
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cpu_rdata <= `LBX_UNMAPPED_READ;
        end
        else if (cpu_rd)
        begin
            unique case (cpu_addr)
                `LBX_OFS_RX_BYTE: cpu_rdata <= rx_link_byte;
                `LBX_OFS_MATCH_ONE: cpu_rdata <= match_one;
                `LBX_OFS_MATCH_TWO: cpu_rdata <= match_two;
                `LBX_OFS_TX_BYTE: cpu_rdata <= tx_written;
                default: cpu_rdata <= `LBX_UNMAPPED_READ;
            endcase
        end
    end

    lbx_buf #(
        .WIDTH(8),
        .DEPTH(BUF_DEPTH)
    ) u_lbx_buf (
        .mclk(mclk),
        .reset_n(reset_n),
        .in_valid(wr_tx),
        .in_ready(buf_ready),
        .in_data(cpu_wdata),
        .out_valid(buf_valid),
        .out_ready(tx_pop),
        .out_data(buf_data)
    );

    assign tx_write_ready = buf_ready;

    // transmit bit selection
    assign tx_slot = ctrl.esf_mode ? tx_link_slot : tx_fs_slot;
    assign tx_alt = !ctrl.esf_mode && ctrl.fs_source_select;
    assign tx_start = (tx_count == 3'h0);
    assign tx_stuff = ctrl.zero_stuff_enable && (tx_ones == `LBX_ONES_RUN);
    assign load_ok = buf_valid && (!ctrl.multiframe_load_enable || tx_mf_boundary);
    assign tx_adv = tx_slot && !tx_alt && !tx_stuff;
    assign tx_pop = tx_adv && tx_start && load_ok;
    assign byte_now = (tx_start && load_ok) ? buf_data : cur_byte;
    assign tx_bit = byte_now[tx_count];

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cur_byte <= `LBX_RST_BYTE;
            tx_count <= 3'h0;
            tx_ones <= 3'h0;
        end
        else if (tx_slot && !tx_alt)
        begin
            if (tx_stuff)
            begin
                tx_ones <= 3'h0;
            end
            else
            begin
                cur_byte <= byte_now;
                tx_count <= tx_count + 3'h1;
                tx_ones <= tx_bit ? ((tx_ones == `LBX_ONES_MAX) ? tx_ones : tx_ones + 3'h1) : 3'h0;
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tx_out <= '0;
        end
        else
        begin
            tx_out.slot <= tx_slot;
            if (tx_slot)
            begin
                tx_out.value <= tx_alt ? fs_alt_bit : (tx_stuff ? 1'b0 : tx_bit);
            end
        end
    end

    // receive destuff and byte assembly
    assign rx_drop = rx_in.slot && ctrl.zero_destuff_enable && !rx_in.value
        && (rx_ones == `LBX_ONES_RUN);
    assign rx_take = rx_in.slot && !rx_drop;
    assign rx_done = rx_take && (rx_count == `LBX_LAST_BIT);
    assign rx_new = {rx_in.value, rx_shift[7:1]};

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rx_shift <= `LBX_RST_BYTE;
            rx_count <= 3'h0;
            rx_ones <= 3'h0;
            rx_link_byte <= `LBX_RST_BYTE;
        end
        else
        begin
            if (rx_in.slot)
            begin
                rx_ones <= !rx_in.value ? 3'h0
                    : ((rx_ones == `LBX_ONES_MAX) ? rx_ones : rx_ones + 3'h1);
            end
            if (rx_take)
            begin
                rx_shift <= rx_new;
                rx_count <= rx_count + 3'h1;
            end
            if (rx_done)
            begin
                rx_link_byte <= rx_new;
            end
        end
    end

    // sticky flags, set wins over clear
    always_comb
    begin
        set_ev.rx_full = rx_done;
        set_ev.match = rx_done && ((rx_new == match_one) || (rx_new == match_two));
        set_ev.tx_empty = tx_adv && (tx_count == `LBX_LAST_BIT);
        next_flags = (flags & ~flag_clear) | set_ev;
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            flags <= '0;
            irq_n <= 1'b1;
        end
        else
        begin
            flags <= next_flags;
            irq_n <= !(|(flags & irq_mask));
        end
    end

    // checks
    chk_match_flag_set: assert property (@(posedge mclk) disable iff (!reset_n)
        rx_done && (rx_new == match_one) |=> flags.match)
        else $error("match flag not set on matching byte");

    chk_match_reg_hold: assert property (@(posedge mclk) disable iff (!reset_n)
        cpu_wr && (cpu_addr == `LBX_OFS_MATCH_TWO) |=> match_two == $past(cpu_wdata))
        else $error("match register did not take written byte");

    chk_slot_source: assert property (@(posedge mclk) disable iff (!reset_n)
        !ctrl.esf_mode && tx_fs_slot |=> tx_out.slot)
        else $error("fs slot not used in d4 mode");

    chk_tx_lsb_first: assert property (@(posedge mclk) disable iff (!reset_n)
        tx_pop |=> tx_out.value == $past(buf_data[0]))
        else $error("loaded byte not sent lsb first");

    chk_tx_empty_set: assert property (@(posedge mclk) disable iff (!reset_n)
        tx_adv && (tx_count == 3'h7) |=> flags.tx_empty && (tx_count == 3'h0))
        else $error("empty flag not set after eighth bit");

    chk_irq_empty: assert property (@(posedge mclk) disable iff (!reset_n)
        flags.tx_empty && irq_mask.tx_empty |=> !irq_n)
        else $error("irq not driven low on masked-in empty");

    chk_tx_repeat: assert property (@(posedge mclk) disable iff (!reset_n)
        tx_adv && tx_start && !load_ok |=> tx_out.value == $past(cur_byte[0]) && cur_byte == $past(cur_byte))
        else $error("held byte not resent");

    chk_tx_stuff_zero: assert property (@(posedge mclk) disable iff (!reset_n)
        tx_slot && !tx_alt && tx_stuff |=> !tx_out.value && (tx_count == $past(tx_count)))
        else $error("stuffed zero missing after five ones");

    chk_mf_load: assert property (@(posedge mclk) disable iff (!reset_n)
        tx_adv && tx_start && buf_valid && ctrl.multiframe_load_enable && !tx_mf_boundary
        |=> (cur_byte == $past(cur_byte)) && buf_valid)
        else $error("byte loaded off multiframe boundary");

    chk_rx_full_set: assert property (@(posedge mclk) disable iff (!reset_n)
        rx_done |=> flags.rx_full && (rx_link_byte == $past(rx_new)) && (rx_count == 3'h0))
        else $error("rx full flag or byte wrong after eight bits");

    chk_rx_destuff: assert property (@(posedge mclk) disable iff (!reset_n)
        rx_drop |=> (rx_count == $past(rx_count)) && (rx_shift == $past(rx_shift)))
        else $error("stuffed zero not removed");

    chk_match_once: assert property (@(posedge mclk) disable iff (!reset_n)
        !rx_done && !$past(flags.match) && !flags.match |=> !flags.match || $past(rx_done))
        else $error("match flag set outside byte completion");

    cov_match_seen: cover property (@(posedge mclk) disable iff (!reset_n) set_ev.match);
    cov_tx_stuff: cover property (@(posedge mclk) disable iff (!reset_n) tx_slot && tx_stuff);
    cov_rx_drop: cover property (@(posedge mclk) disable iff (!reset_n) rx_drop);
    cov_buf_full: cover property (@(posedge mclk) disable iff (!reset_n) wr_tx && !buf_ready);

endmodule

// ---- lbx_pkg.sv ----
// types shared by the legacy link byte path
// assumes nothing of its surroundings
package lbx_pkg;

    // one serial bit position of the framer stream
    typedef struct packed {
        logic slot;
        logic value;
    } lbx_bit_s;

    // framing and stuffing controls held by the host
    typedef struct packed {
        logic esf_mode;
        logic zero_stuff_enable;
        logic zero_destuff_enable;
        logic multiframe_load_enable;
        logic fs_source_select;
    } lbx_ctrl_s;

    // status flags, irq masks and clear pulses share this layout
    typedef struct packed {
        logic rx_full;
        logic tx_empty;
        logic match;
    } lbx_flags_s;

endpackage

// ---- legacy_link_byte_insert_extract_test.sv ----
// self-checking bench of the legacy link byte path
// assumes the far-end model drives the receive stream and captures transmit bits
`timescale 1ns/1ps
module legacy_link_byte_insert_extract_test;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] cpu_addr = 8'h00;
    logic cpu_wr = 1'b0;
    logic cpu_rd = 1'b0;
    logic [7:0] cpu_wdata = 8'h00;
    logic [7:0] cpu_rdata;
    logic tx_write_ready;
    lbx_pkg::lbx_ctrl_s ctrl = '0;
    lbx_pkg::lbx_flags_s irq_mask = '0;
    lbx_pkg::lbx_flags_s flag_clear = '0;
    lbx_pkg::lbx_flags_s flags;
    logic irq_n;
    lbx_pkg::lbx_bit_s rx_in;
    logic tx_link_slot = 1'b0;
    logic tx_fs_slot = 1'b0;
    logic tx_mf_boundary = 1'b0;
    logic fs_alt_bit = 1'b0;
    lbx_pkg::lbx_bit_s tx_out;
    logic rx_go = 1'b0;
    logic [7:0] rx_byte = 8'h00;
    logic rx_busy;
    logic [15:0] tx_cap;
    int n_errors = 0;
    int checks_done = 0;

    lbx_link_byte #(.BUF_DEPTH(2)) u_lbx_link_byte (.mclk, .reset_n, .cpu_addr, .cpu_wr, .cpu_rd,
        .cpu_wdata, .cpu_rdata, .tx_write_ready, .ctrl, .irq_mask, .flag_clear, .flags, .irq_n,
        .rx_in, .tx_link_slot, .tx_fs_slot, .tx_mf_boundary, .fs_alt_bit, .tx_out);
    lbx_far_end u_lbx_far_end (.mclk, .rx_go, .rx_byte, .rx_in, .rx_busy, .tx_out, .tx_cap);

    initial
    begin
        forever #4 mclk = ~mclk;
    end

    task automatic finish_test();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp, input string what);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %0t %s got %b", $time, what, got);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        cpu_addr = a;
        cpu_wdata = d;
        cpu_wr = 1'b1;
        @(negedge mclk);
        cpu_wr = 1'b0;
        @(negedge mclk);
    endtask

    task automatic check_reg(input logic [7:0] a, input logic [7:0] exp);
        cpu_addr = a;
        cpu_rd = 1'b1;
        @(negedge mclk);
        cpu_rd = 1'b0;
        cmp_byte(cpu_rdata, exp, "register read");
        @(negedge mclk);
    endtask

    task automatic clear_flags();
        flag_clear = 3'h7;
        @(negedge mclk);
        flag_clear = 3'h0;
        repeat (2) @(negedge mclk);
    endtask

    task automatic slots(input int n, input logic mf);
        for (int i = 0; i < n; i++)
        begin
            tx_link_slot = ctrl.esf_mode;
            tx_fs_slot = !ctrl.esf_mode;
            tx_mf_boundary = mf && (i == 0);
            @(negedge mclk);
            tx_link_slot = 1'b0;
            tx_fs_slot = 1'b0;
            tx_mf_boundary = 1'b0;
            repeat (2) @(negedge mclk);
        end
    endtask

    task automatic rx_send(input logic [7:0] b);
        int k;
        rx_byte = b;
        rx_go = 1'b1;
        @(negedge mclk);
        rx_go = 1'b0;
        k = 0;
        while (rx_busy !== 1'b0 && k < 40)
        begin
            @(negedge mclk);
            k++;
        end
        if (k >= 40)
        begin
            n_errors++;
            $display("[FAIL] %0t receive stream hung", $time);
            finish_test();
        end
        repeat (2) @(negedge mclk);
    endtask

    task automatic test_regs();
        check_reg(8'h28, 8'h00);
        check_reg(8'h29, 8'h00);
        check_reg(8'h7e, 8'h00);
        reg_wr(8'h29, 8'ha5);
        reg_wr(8'h2a, 8'h3c);
        reg_wr(8'h28, 8'hff);
        reg_wr(8'h10, 8'h55);
        check_reg(8'h29, 8'ha5);
        check_reg(8'h2a, 8'h3c);
        check_reg(8'h28, 8'h00);
        check_reg(8'h10, 8'h00);
        $display("regs done");
    endtask

    task automatic test_rx();
        irq_mask = 3'b101;
        rx_send(8'h3c);
        check_reg(8'h28, 8'h3c);
        cmp_byte({5'h00, flags}, 8'h05, "match two flags");
        cmp_bit(irq_n, 1'b0, "match irq");
        clear_flags();
        cmp_bit(irq_n, 1'b1, "irq released");
        rx_send(8'h5a);
        check_reg(8'h28, 8'h5a);
        cmp_byte({5'h00, flags}, 8'h04, "no match flags");
        cmp_bit(irq_n, 1'b0, "full irq");
        clear_flags();
        irq_mask = 3'b001;
        rx_send(8'ha5);
        cmp_byte({5'h00, flags}, 8'h05, "match one flags");
        cmp_bit(irq_n, 1'b0, "match only irq");
        clear_flags();
        ctrl.zero_destuff_enable = 1'b1;
        rx_send(8'h0f);
        rx_send(8'h3f);
        check_reg(8'h28, 8'h8f);
        cmp_bit(irq_n, 1'b1, "no match irq");
        rx_send(8'h00);
        check_reg(8'h28, 8'h1f);
        ctrl.zero_destuff_enable = 1'b0;
        clear_flags();
        $display("rx done");
    endtask

    task automatic test_tx_esf();
        ctrl.esf_mode = 1'b1;
        irq_mask = 3'b010;
        reg_wr(8'h7e, 8'h96);
        check_reg(8'h7e, 8'h96);
        slots(7, 1'b0);
        cmp_byte({5'h00, flags}, 8'h00, "empty too early");
        slots(1, 1'b0);
        cmp_byte(tx_cap[15:8], 8'h96, "esf byte");
        cmp_byte({5'h00, flags}, 8'h02, "tx empty");
        cmp_bit(irq_n, 1'b0, "empty irq");
        clear_flags();
        irq_mask = 3'b000;
        slots(8, 1'b0);
        cmp_byte(tx_cap[15:8], 8'h96, "resend");
        cmp_bit(irq_n, 1'b1, "masked irq");
        clear_flags();
        $display("esf done");
    endtask

    task automatic test_tx_d4();
        ctrl = 5'b00010;
        reg_wr(8'h7e, 8'h1c);
        slots(8, 1'b0);
        cmp_byte(tx_cap[15:8], 8'h96, "held without boundary");
        slots(8, 1'b1);
        cmp_byte(tx_cap[15:8], 8'h1c, "fs pattern");
        ctrl.fs_source_select = 1'b1;
        fs_alt_bit = 1'b1;
        slots(1, 1'b0);
        cmp_bit(tx_out.value, 1'b1, "other fs source");
        ctrl = 5'b10000;
        fs_alt_bit = 1'b0;
        clear_flags();
        $display("d4 done");
    endtask

    task automatic test_buffer();
        reg_wr(8'h7e, 8'h11);
        cmp_bit(tx_write_ready, 1'b1, "one entry");
        reg_wr(8'h7e, 8'h22);
        cmp_bit(tx_write_ready, 1'b0, "buffer full");
        reg_wr(8'h7e, 8'h33);
        check_reg(8'h7e, 8'h22);
        slots(16, 1'b0);
        cmp_byte(tx_cap[7:0], 8'h11, "first queued");
        cmp_byte(tx_cap[15:8], 8'h22, "second queued");
        cmp_bit(tx_write_ready, 1'b1, "drained");
        $display("buffer done");
    endtask

    task automatic test_stuff();
        ctrl.zero_stuff_enable = 1'b1;
        ctrl.zero_destuff_enable = 1'b1;
        reg_wr(8'h7e, 8'hff);
        slots(9, 1'b0);
        cmp_byte(tx_cap[15:8], 8'hef, "stuffed zero");
        cmp_bit(tx_cap[7], 1'b1, "first one");
        $display("stuff done");
    endtask

    initial
    begin
        repeat (6) @(negedge mclk);
        reset_n = 1'b1;
        @(negedge mclk);
        test_regs();
        test_rx();
        test_tx_esf();
        test_tx_d4();
        test_buffer();
        test_stuff();
        finish_test();
    end
endmodule
